// [stc_timer.sv]
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module stc_timer (
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        SYS_RST,
  // Register port
  input  wire logic [stc_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [stc_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR_STB,
  input  wire logic                        RD_STB,
  output logic      [stc_pkg::DATA_W-1:0]  RDATA,
  // Timer input pins
  input  wire logic                        EXTERNAL_CLOCK_PIN,
  input  wire logic                        CAPTURE_INPUT_PIN,
  // Port direction bits of the compare pins
  input  wire logic                        COMPARE_A_DIR_OUT,
  input  wire logic                        COMPARE_B_DIR_OUT,
  // Compare output pins
  output logic                             COMPARE_A_PIN_O,
  output logic                             COMPARE_A_PIN_OE_N,
  output logic                             COMPARE_B_PIN_O,
  output logic                             COMPARE_B_PIN_OE_N
);
  import stc_pkg::*;

  // Register file state
  logic [DATA_W-1:0] ctrl_a_reg;     // timer_control_a, force bits not stored
  logic [DATA_W-1:0] ctrl_a_next;
  logic [DATA_W-1:0] ctrl_b_reg;     // timer_control_b
  logic [DATA_W-1:0] ctrl_b_next;
  logic [CNT_W-1:0]  cmpa_reg;       // compare_a_register
  logic [CNT_W-1:0]  cmpa_next;
  logic [CNT_W-1:0]  cmpb_reg;       // compare_b_register
  logic [CNT_W-1:0]  cmpb_next;
  logic [DATA_W-1:0] temp_reg;       // Shared holding byte
  logic [DATA_W-1:0] temp_next;
  logic [DATA_W-1:0] rdata_reg;      // Read data, valid the cycle after
  logic [DATA_W-1:0] rdata_next;

  // Counter state
  logic [CNT_W-1:0]  cnt_reg;        // counter_value
  logic [CNT_W-1:0]  cnt_next;
  logic [CNT_W-1:0]  cap_reg;        // capture_register
  logic [CNT_W-1:0]  cap_next;
  stc_dir_t          dir_reg;        // Up/down PWM direction
  stc_dir_t          dir_next;
  logic              block_reg;      // Suppress matches after a preset
  logic              block_next;

  // Decoded controls and events
  stc_pwm_t          pwm;            // PWM resolution
  logic              pwm_on;         // Any PWM mode
  logic              clear_bit;      // clear_on_compare
  logic [CNT_W-1:0]  top;            // Resolution top in PWM
  logic              tick;           // Counter advance
  logic              cap_trig;       // Capture event
  logic              wr_ctrl_a;      // Write to timer_control_a
  logic              cnt_load;       // Low-byte counter write
  logic              ovf;            // Wrap in PWM up-count style
  logic [1:0]        mode [2];       // Per-channel output mode
  logic [CNT_W-1:0]  cmp [2];        // Per-channel compare value
  logic [1:0]        force_hit;      // Forced match per channel
  logic [1:0]        match;          // Real match per channel
  logic [1:0]        dir_out;        // Port direction per channel
  logic [1:0]        pin_reg;        // Compare pin levels
  logic [1:0]        oe_n_reg;       // Compare pin enables, low drives

  // Counter clock enable from the clock select field
  stc_tick_gen u_tick (
    .clk     (CLK),
    .rst     (SYS_RST),
    .clk_sel (ctrl_b_reg[CB_CS_HI:CB_CS_LO]),
    .ext_pin (EXTERNAL_CLOCK_PIN),
    .tick    (tick)
  );

  // Capture edge detector
  stc_cap_detect u_cap (
    .clk       (CLK),
    .rst       (SYS_RST),
    .filter_en (ctrl_b_reg[CB_FILTER]),
    .edge_rise (ctrl_b_reg[CB_EDGE]),
    .cap_pin   (CAPTURE_INPUT_PIN),
    .trig      (cap_trig)
  );

  // Decode mode fields and match conditions
  always_comb begin
    pwm       = stc_pwm_t'(ctrl_a_reg[CA_PWM_HI:CA_PWM_LO]);
    pwm_on    = (pwm != PWM_NONE);
    clear_bit = ctrl_b_reg[CB_CLEAR];
    // Resolution top per PWM select
    case (pwm)
      PWM_8:   top = TOP_8;
      PWM_9:   top = TOP_9;
      PWM_10:  top = TOP_10;
      default: top = '1;
    endcase
    wr_ctrl_a = WR_STB && (ADDR == ADR_CTRL_A);
    cnt_load  = WR_STB && (ADDR == ADR_CNT_LO);
    mode[0]   = ctrl_a_reg[CA_MODE_A_HI:CA_MODE_A_LO];
    mode[1]   = ctrl_a_reg[CA_MODE_B_HI:CA_MODE_B_LO];
    cmp[0]    = pwm_on ? (cmpa_reg & top) : cmpa_reg;
    cmp[1]    = pwm_on ? (cmpb_reg & top) : cmpb_reg;
    dir_out   = {COMPARE_B_DIR_OUT, COMPARE_A_DIR_OUT};
    // Forced matches act only outside PWM
    force_hit[0] = wr_ctrl_a && WDATA[CA_FORCE_A] && !pwm_on;
    force_hit[1] = wr_ctrl_a && WDATA[CA_FORCE_B] && !pwm_on;
    // A preset blocks matches for one timer cycle
    match[0]  = tick && !block_reg && (cnt_reg == cmp[0]);
    match[1]  = tick && !block_reg && (cnt_reg == cmp[1]);
    ovf       = tick && pwm_on && clear_bit && (cnt_reg >= top);
  end

  // Register port: writes, holding byte and read data
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    cmpa_next   = cmpa_reg;
    cmpb_next   = cmpb_reg;
    temp_next   = temp_reg;
    rdata_next  = BYTE_RST;
    if (WR_STB) begin
      case (ADDR)
        // Force bits pulse only; they are not stored
        ADR_CTRL_A:  ctrl_a_next = WDATA & CTRL_A_WMASK;
        // Reserved bits never stored
        ADR_CTRL_B:  ctrl_b_next = WDATA & CTRL_B_WMASK;
        // High bytes park in the holding byte
        ADR_CNT_HI:  temp_next = WDATA;
        ADR_CMPA_HI: temp_next = WDATA;
        ADR_CMPB_HI: temp_next = WDATA;
        // Low bytes complete the 16-bit load
        ADR_CMPA_LO: cmpa_next = {temp_reg, WDATA};
        ADR_CMPB_LO: cmpb_next = {temp_reg, WDATA};
        default:     ctrl_a_next = ctrl_a_reg;
      endcase
    end else if (RD_STB) begin
      case (ADDR)
        ADR_CTRL_A:  rdata_next = ctrl_a_reg;
        ADR_CTRL_B:  rdata_next = ctrl_b_reg;
        ADR_CMPA_LO: rdata_next = cmpa_reg[7:0];
        ADR_CMPA_HI: rdata_next = cmpa_reg[15:8];
        ADR_CMPB_LO: rdata_next = cmpb_reg[7:0];
        ADR_CMPB_HI: rdata_next = cmpb_reg[15:8];
        // Low read snapshots the high byte
        ADR_CNT_LO: begin
          rdata_next = cnt_reg[7:0];
          temp_next  = cnt_reg[15:8];
        end
        ADR_CNT_HI:  rdata_next = temp_reg;
        ADR_CAP_LO: begin
          rdata_next = cap_reg[7:0];
          temp_next  = cap_reg[15:8];
        end
        ADR_CAP_HI:  rdata_next = temp_reg;
        // Unmapped reads return zero
        default:     rdata_next = BYTE_RST;
      endcase
    end
  end

  // Register the register file
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_a_reg <= BYTE_RST;
      ctrl_b_reg <= BYTE_RST;
      cmpa_reg   <= CNT_RST;
      cmpb_reg   <= CNT_RST;
      temp_reg   <= BYTE_RST;
      rdata_reg  <= BYTE_RST;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      cmpa_reg   <= cmpa_next;
      cmpb_reg   <= cmpb_next;
      temp_reg   <= temp_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Counter, direction, match blocking and capture
  always_comb begin
    cnt_next   = cnt_reg;
    dir_next   = dir_reg;
    block_next = block_reg;
    cap_next   = cap_reg;
    if (cap_trig) begin
      cap_next = cnt_reg;
    end
    if (cnt_load) begin
      // Preset wins over a tick; counting resumes next tick
      cnt_next   = {temp_reg, WDATA};
      block_next = 1'b1;
    end else if (tick) begin
      block_next = 1'b0;
      if (!pwm_on) begin
        // Only a real A match clears; forced ones never do
        if (clear_bit && match[0]) begin
          cnt_next = CNT_RST;
        end else begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end else if (clear_bit) begin
        // Up-count wrapping at top
        if (cnt_reg >= top) begin
          cnt_next = CNT_RST;
        end else begin
          cnt_next = (cnt_reg + CNT_ONE) & top;
        end
      end else begin
        // Up/down between zero and top
        case (dir_reg)
          DIR_UP: begin
            if (cnt_reg >= top) begin
              dir_next = DIR_DOWN;
              cnt_next = (cnt_reg - CNT_ONE) & top;
            end else begin
              cnt_next = cnt_reg + CNT_ONE;
            end
          end
          DIR_DOWN: begin
            if (cnt_reg == CNT_RST) begin
              dir_next = DIR_UP;
              cnt_next = CNT_ONE;
            end else begin
              cnt_next = cnt_reg - CNT_ONE;
            end
          end
          default: dir_next = DIR_UP;
        endcase
      end
    end
  end

  // Register the counter group
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_reg   <= CNT_RST;
      dir_reg   <= DIR_UP;
      block_reg <= 1'b0;
      cap_reg   <= CNT_RST;
    end else begin
      cnt_reg   <= cnt_next;
      dir_reg   <= dir_next;
      block_reg <= block_next;
      cap_reg   <= cap_next;
    end
  end

  // Compare output pin logic, one copy per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic pin_next;
      logic oe_n_next;
      logic connected;

      // Work out pin level and drive enable
      always_comb begin
        pin_next  = pin_reg[ch];
        connected = pwm_on ? mode[ch][1] : (mode[ch] != OUT_OFF);
        // Drive only when the port bit selects output
        oe_n_next = !(dir_out[ch] && connected);
        if (!pwm_on) begin
          // Mode register is the old value on a combined write
          if (match[ch] || force_hit[ch]) begin
            case (stc_out_mode_t'(mode[ch]))
              OUT_TOGGLE: pin_next = ~pin_reg[ch];
              OUT_CLEAR:  pin_next = 1'b0;
              OUT_SET:    pin_next = 1'b1;
              default:    pin_next = pin_reg[ch];
            endcase
          end
        end else if (!clear_bit) begin
          // Up/down: level depends on direction at the match
          if (match[ch]) begin
            case (stc_out_mode_t'(mode[ch]))
              OUT_CLEAR: pin_next = (dir_reg == DIR_DOWN);
              OUT_SET:   pin_next = (dir_reg == DIR_UP);
              default:   pin_next = pin_reg[ch];
            endcase
          end
        end else begin
          // Wrapping: match and wrap act oppositely
          case (stc_out_mode_t'(mode[ch]))
            OUT_CLEAR: begin
              if (match[ch]) begin
                pin_next = 1'b0;
              end else if (ovf) begin
                pin_next = 1'b1;
              end
            end
            OUT_SET: begin
              if (match[ch]) begin
                pin_next = 1'b1;
              end else if (ovf) begin
                pin_next = 1'b0;
              end
            end
            default: pin_next = pin_reg[ch];
          endcase
        end
      end

      // Register pin level and enable
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          pin_reg[ch]  <= 1'b0;
          oe_n_reg[ch] <= 1'b1;
        end else begin
          pin_reg[ch]  <= pin_next;
          oe_n_reg[ch] <= oe_n_next;
        end
      end
    end
  endgenerate

  // Outputs straight from flip-flops
  assign RDATA              = rdata_reg;
  assign COMPARE_A_PIN_O    = pin_reg[0];
  assign COMPARE_A_PIN_OE_N = oe_n_reg[0];
  assign COMPARE_B_PIN_O    = pin_reg[1];
  assign COMPARE_B_PIN_OE_N = oe_n_reg[1];

endmodule
`default_nettype wire

// [stc_pkg.sv]
// Shared constants and types of the sixteen-bit timer control block
package stc_pkg;

  // Bus and datapath widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 10;

  // Register offsets on the byte-wide register port
  localparam logic [5:0] ADR_CAP_LO  = 6'h24;
  localparam logic [5:0] ADR_CAP_HI  = 6'h25;
  localparam logic [5:0] ADR_CMPB_LO = 6'h28;
  localparam logic [5:0] ADR_CMPB_HI = 6'h29;
  localparam logic [5:0] ADR_CMPA_LO = 6'h2a;
  localparam logic [5:0] ADR_CMPA_HI = 6'h2b;
  localparam logic [5:0] ADR_CNT_LO  = 6'h2c;
  localparam logic [5:0] ADR_CNT_HI  = 6'h2d;
  localparam logic [5:0] ADR_CTRL_B  = 6'h2e;
  localparam logic [5:0] ADR_CTRL_A  = 6'h2f;

  // Field positions in timer_control_a
  localparam int CA_MODE_A_HI = 7;
  localparam int CA_MODE_A_LO = 6;
  localparam int CA_MODE_B_HI = 5;
  localparam int CA_MODE_B_LO = 4;
  localparam int CA_FORCE_A   = 3;
  localparam int CA_FORCE_B   = 2;
  localparam int CA_PWM_HI    = 1;
  localparam int CA_PWM_LO    = 0;

  // Field positions in timer_control_b
  localparam int CB_FILTER = 7;
  localparam int CB_EDGE   = 6;
  localparam int CB_CLEAR  = 3;
  localparam int CB_CS_HI  = 2;
  localparam int CB_CS_LO  = 0;

  // Writable bits; force bits and reserved bits are never stored
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_B_WMASK = 8'hcf;

  // Reset values
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // Resolution tops in PWM
  localparam logic [15:0] TOP_8  = 16'h00ff;
  localparam logic [15:0] TOP_9  = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;

  // Prescaler terminal masks
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV64_MASK   = 10'h03f;
  localparam logic [9:0] DIV256_MASK  = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  localparam logic [9:0] PRE_ONE      = 10'h001;

  // Samples that must agree with the capture filter on
  localparam int FILTER_SAMPLES = 4;

  // Compare-output action
  typedef enum logic [1:0] {
    OUT_OFF    = 2'b00,
    OUT_TOGGLE = 2'b01,
    OUT_CLEAR  = 2'b10,
    OUT_SET    = 2'b11
  } stc_out_mode_t;

  // PWM resolution select
  typedef enum logic [1:0] {
    PWM_NONE = 2'b00,
    PWM_8    = 2'b01,
    PWM_9    = 2'b10,
    PWM_10   = 2'b11
  } stc_pwm_t;

  // Counter clock select
  typedef enum logic [2:0] {
    CS_STOP     = 3'b000,
    CS_SYS      = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } stc_clk_sel_t;

  // Counting direction in up/down PWM
  typedef enum logic [0:0] {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } stc_dir_t;

endpackage

// [stc_tick_gen.sv]
`timescale 1ns/1ns
`default_nettype none
// Prescaler and external-edge counter clock enable
module stc_tick_gen (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Selection and external clock pin
  input  wire logic [2:0]          clk_sel,
  input  wire logic                ext_pin,
  // One-cycle counter advance
  output logic                     tick
);
  import stc_pkg::*;

  logic [PRE_W-1:0] pre_reg;      // Free-running prescaler
  logic [PRE_W-1:0] pre_next;
  logic             ext_prev_reg; // Previous external pin sample
  logic             tick_reg;     // Registered advance pulse
  logic             tick_next;

  // Select the advance condition
  always_comb begin
    pre_next  = pre_reg + PRE_ONE;
    tick_next = 1'b0;
    case (stc_clk_sel_t'(clk_sel))
      CS_STOP:     tick_next = 1'b0;
      CS_SYS:      tick_next = 1'b1;
      CS_DIV8:     tick_next = ((pre_reg & DIV8_MASK) == DIV8_MASK);
      CS_DIV64:    tick_next = ((pre_reg & DIV64_MASK) == DIV64_MASK);
      CS_DIV256:   tick_next = ((pre_reg & DIV256_MASK) == DIV256_MASK);
      CS_DIV1024:  tick_next = ((pre_reg & DIV1024_MASK) == DIV1024_MASK);
      // Pin edges count whatever the pin direction
      CS_EXT_FALL: tick_next = ext_prev_reg & ~ext_pin;
      CS_EXT_RISE: tick_next = ~ext_prev_reg & ext_pin;
      default:     tick_next = 1'b0;
    endcase
  end

  // Register prescaler, pin sample and pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg      <= '0;
      ext_prev_reg <= 1'b0;
      tick_reg     <= 1'b0;
    end else begin
      pre_reg      <= pre_next;
      ext_prev_reg <= ext_pin;
      tick_reg     <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// [stc_cap_detect.sv]
`timescale 1ns/1ns
`default_nettype none
// Capture input edge detector with optional four-sample filter
module stc_cap_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Configuration and pin
  input  wire logic filter_en,
  input  wire logic edge_rise,
  input  wire logic cap_pin,
  // One-cycle capture trigger
  output logic      trig
);
  import stc_pkg::*;

  logic [FILTER_SAMPLES-2:0] hist_reg;  // Older samples, bit 0 newest
  logic [FILTER_SAMPLES-2:0] hist_next;
  logic                      lvl_reg;   // Filtered level
  logic                      lvl_next;
  logic                      trig_reg;
  logic                      trig_next;
  logic [FILTER_SAMPLES-1:0] win;       // Newest four samples

  // Detect the chosen edge
  always_comb begin
    win       = {hist_reg, cap_pin};
    hist_next = win[FILTER_SAMPLES-2:0];
    lvl_next  = lvl_reg;
    if (win == '1) begin
      lvl_next = 1'b1;
    end else if (win == '0) begin
      lvl_next = 1'b0;
    end
    if (filter_en) begin
      // Four agreeing samples at the target level
      trig_next = (lvl_reg != edge_rise) && (lvl_next == edge_rise);
    end else begin
      // First sampled edge of the chosen polarity
      trig_next = (cap_pin == edge_rise) && (hist_reg[0] != edge_rise);
    end
  end

  // Register history and trigger
  always_ff @(posedge clk) begin
    if (rst) begin
      hist_reg <= '0;
      lvl_reg  <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      lvl_reg  <= lvl_next;
      trig_reg <= trig_next;
    end
  end

  assign trig = trig_reg;

endmodule
`default_nettype wire

// [stc_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
// CPU side of the byte-wide register port
module stc_cpu_model (
  // Clock
  input  wire logic                       clk,
  // Register port as the core drives it
  output logic      [stc_pkg::ADDR_W-1:0] addr,
  output logic      [stc_pkg::DATA_W-1:0] wdata,
  output logic                            wr_stb,
  output logic                            rd_stb,
  input  wire logic [stc_pkg::DATA_W-1:0] rdata
);
  import stc_pkg::*;
  // Idle bus at time zero
  initial {addr, wdata, wr_stb, rd_stb} = '0;
  // Released lines show the inverse of their last value
  task automatic rel();
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
  // One write cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rel();
  endtask
  // One read cycle; data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    rel();
    #1 d = rdata;
  endtask
  // Wide write: high byte first, through the shared holding byte
  task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
    wr(lo + 6'h01, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // Wide read: low byte first
  task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 6'h01, v[15:8]);
  endtask
endmodule
`default_nettype wire

// [stc_timer_props.sv]
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the timer control block
module stc_timer_props (
  // Clock and reset
  input wire logic                       CLK,
  input wire logic                       SYS_RST,
  // Register port
  input wire logic [stc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [stc_pkg::DATA_W-1:0] WDATA,
  input wire logic                       WR_STB,
  input wire logic                       RD_STB,
  input wire logic [stc_pkg::DATA_W-1:0] RDATA,
  // Pins
  input wire logic                       EXTERNAL_CLOCK_PIN,
  input wire logic                       CAPTURE_INPUT_PIN,
  input wire logic                       COMPARE_A_DIR_OUT,
  input wire logic                       COMPARE_B_DIR_OUT,
  input wire logic                       COMPARE_A_PIN_O,
  input wire logic                       COMPARE_A_PIN_OE_N,
  input wire logic                       COMPARE_B_PIN_O,
  input wire logic                       COMPARE_B_PIN_OE_N
);
  import stc_pkg::*;
  logic [7:0] ctrl_a_reg;  // Control A as software stored it
  logic [7:0] ctrl_a_next; // Its next value
  // Follow control A writes
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    if (WR_STB && ADDR == ADR_CTRL_A) begin
      ctrl_a_next = WDATA & CTRL_A_WMASK;
    end
  end
  // Register the copy
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_a_reg <= BYTE_RST;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Force on channel B written outside PWM
  sequence force_b_seq;
    WR_STB && ADDR == ADR_CTRL_A && WDATA[CA_FORCE_B] && ctrl_a_reg[1:0] == 2'b00;
  endsequence
  chk_force_set_b: assert property (force_b_seq ##0 ctrl_a_reg[5:4] == 2'b11
    |=> COMPARE_B_PIN_O)
    else $error("forced set did not drive B high");
  chk_force_clr_b: assert property (force_b_seq ##0 ctrl_a_reg[5:4] == 2'b10
    |=> !COMPARE_B_PIN_O)
    else $error("forced clear did not drive B low");
  chk_force_tgl_b: assert property (force_b_seq ##0 ctrl_a_reg[5:4] == 2'b01
    |=> COMPARE_B_PIN_O != $past(COMPARE_B_PIN_O))
    else $error("forced toggle did not flip B");
  chk_dir_gate_a: assert property (!COMPARE_A_DIR_OUT [*2] |-> COMPARE_A_PIN_OE_N)
    else $error("A driven with direction input");
  chk_dir_gate_b: assert property (!COMPARE_B_DIR_OUT [*2] |-> COMPARE_B_PIN_OE_N)
    else $error("B driven with direction input");
  chk_mode_off_b: assert property (ctrl_a_reg[5:4] == 2'b00 [*2] |-> COMPARE_B_PIN_OE_N)
    else $error("B driven while disconnected");
  chk_resv_zero: assert property (RD_STB && ADDR == ADR_CTRL_B |=> RDATA[5:4] == 2'b00)
    else $error("reserved control B bits not zero");
  chk_force_rd0: assert property (RD_STB && ADDR == ADR_CTRL_A |=> RDATA[3:2] == 2'b00)
    else $error("force bits did not read zero");
endmodule
bind stc_timer stc_timer_props i_props (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .EXTERNAL_CLOCK_PIN(EXTERNAL_CLOCK_PIN), .CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN),
  .COMPARE_A_DIR_OUT(COMPARE_A_DIR_OUT), .COMPARE_B_DIR_OUT(COMPARE_B_DIR_OUT),
  .COMPARE_A_PIN_O(COMPARE_A_PIN_O), .COMPARE_A_PIN_OE_N(COMPARE_A_PIN_OE_N),
  .COMPARE_B_PIN_O(COMPARE_B_PIN_O), .COMPARE_B_PIN_OE_N(COMPARE_B_PIN_OE_N));
`default_nettype wire

// [test_stc_timer.sv]
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench of the timer control block
module test_stc_timer;
  import stc_pkg::*;
  logic        clk = 1'b0;     // System clock
  logic        rst = 1'b1;     // Synchronous reset
  logic [5:0]  addr;           // Bus from the core model
  logic [7:0]  wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata;
  logic        ext_pin = 1'b0; // External count pin
  logic        cap_pin = 1'b0; // Capture pin
  logic        dir_a = 1'b0;   // Direction bits
  logic        dir_b = 1'b0;
  logic        pin_a, oe_a_n, pin_b, oe_b_n;
  logic [15:0] v;              // Last wide read
  int          miscompares = 0;
  int          total_checks = 0;
  int          dv[5] = '{1, 8, 64, 256, 1024};
  logic [15:0] tops[4] = '{CNT_RST, TOP_8, TOP_9, TOP_10};
  // Clock at 50 ns
  always #25 clk = ~clk;
  stc_timer i_dut (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .EXTERNAL_CLOCK_PIN(ext_pin), .CAPTURE_INPUT_PIN(cap_pin),
    .COMPARE_A_DIR_OUT(dir_a), .COMPARE_B_DIR_OUT(dir_b), .COMPARE_A_PIN_O(pin_a),
    .COMPARE_A_PIN_OE_N(oe_a_n), .COMPARE_B_PIN_O(pin_b), .COMPARE_B_PIN_OE_N(oe_b_n));
  stc_cpu_model i_cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Preset, select for n+2 cycles, stop, read back
  task automatic run(input logic [7:0] ctl, input int n, input logic [15:0] pre);
    i_cpu.wr16(ADR_CNT_LO, pre);
    i_cpu.wr(ADR_CTRL_B, ctl);
    repeat (n) @(posedge clk);
    i_cpu.wr(ADR_CTRL_B, BYTE_RST);
    i_cpu.rd16(ADR_CNT_LO, v);
  endtask
  // Reset values, reserved and force bits, unmapped place
  task automatic t_regs();
    logic [5:0] rmap[6] = '{ADR_CTRL_B, ADR_CNT_LO, ADR_CNT_HI, ADR_CMPA_LO, ADR_CMPA_HI, 6'h3f};
    logic [7:0] b;
    foreach (rmap[i]) begin
      i_cpu.rd(rmap[i], b);
      check(16'(b), 16'h0000);
    end
    i_cpu.wr(ADR_CTRL_B, 8'hff);
    i_cpu.rd(ADR_CTRL_B, b);
    check(16'(b), 16'h00cf);
    i_cpu.wr(ADR_CTRL_A, 8'hff);
    i_cpu.rd(ADR_CTRL_A, b);
    check(16'(b), 16'h00f3);
    i_cpu.wr(ADR_CTRL_A, BYTE_RST);
    i_cpu.wr(ADR_CTRL_B, BYTE_RST);
  endtask
  // Holding byte: lone high write is not applied; low read refreshes it
  task automatic t_bytes();
    i_cpu.wr16(ADR_CNT_LO, 16'ha55a);
    i_cpu.rd16(ADR_CNT_LO, v);
    check(v, 16'ha55a);
    i_cpu.wr(ADR_CNT_HI, 8'h3c);
    i_cpu.rd16(ADR_CNT_LO, v);
    check(v, 16'ha55a);
  endtask
  // Each clock source for two ticks, then external edges
  task automatic t_div();
    for (int i = 0; i < 5; i++) begin
      run(8'(i + 1), 2 * dv[i] - 2, CNT_RST);
      check(v, 16'h0002);
    end
    run(8'h00, 8, CNT_RST);
    check(v, CNT_RST);
    for (int m = 6; m < 8; m++) begin
      i_cpu.wr16(ADR_CNT_LO, CNT_RST);
      i_cpu.wr(ADR_CTRL_B, 8'(m));
      repeat (6) @(posedge clk) ext_pin <= ~ext_pin;
      repeat (4) @(posedge clk);
      i_cpu.wr(ADR_CTRL_B, BYTE_RST);
      i_cpu.rd16(ADR_CNT_LO, v);
      check(v, 16'h0003);
    end
  endtask
  // Clear on compare A against free counting
  task automatic t_clear();
    i_cpu.wr16(ADR_CMPA_LO, 16'h0005);
    run(8'h09, 18, CNT_RST);
    check(v, 16'h0002);
    run(8'h01, 18, CNT_RST);
    check(v, 16'h0014);
    i_cpu.wr16(ADR_CMPA_LO, CNT_RST);
  endtask
  // Wrap at each top, then an up/down turn that sets B going down
  task automatic t_pwm();
    for (int p = 1; p < 4; p++) begin
      i_cpu.wr(ADR_CTRL_A, 8'(p));
      run(8'h09, 1, tops[p] - CNT_ONE);
      check(v, CNT_ONE);
    end
    i_cpu.wr16(ADR_CMPB_LO, 16'h00fe);
    i_cpu.wr(ADR_CTRL_A, 8'h21);
    run(8'h01, 1, TOP_8 - CNT_ONE);
    check(v, TOP_8 - 16'h0002);
    check(16'(pin_b), 16'h0001);
    i_cpu.wr(ADR_CTRL_A, BYTE_RST);
  endtask
  // Forces use the old mode; no counter clear
  task automatic t_force();
    logic [1:0] md[6] = '{2'b11, 2'b10, 2'b10, 2'b01, 2'b01, 2'b01};
    logic       ex[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    @(posedge clk) dir_a <= 1'b1;
    dir_b <= 1'b1;
    i_cpu.wr16(ADR_CNT_LO, 16'h0033);
    i_cpu.wr(ADR_CTRL_B, 8'h08);
    i_cpu.wr(ADR_CTRL_A, 8'hf0);
    for (int i = 0; i < 6; i++) begin
      i_cpu.wr(ADR_CTRL_A, {md[i], md[i], 4'hc});
      #1 check(16'({pin_a, pin_b}), 16'({ex[i], ex[i]}));
    end
    check(16'({oe_a_n, oe_b_n}), 16'h0000);
    i_cpu.rd16(ADR_CNT_LO, v);
    check(v, 16'h0033);
    @(posedge clk) dir_b <= 1'b0;
    repeat (3) @(posedge clk);
    check(16'(oe_b_n), 16'h0001);
    i_cpu.wr(ADR_CTRL_B, BYTE_RST);
  endtask
  // Capture pulse of n high samples, then read the capture register
  task automatic pulse(input int n);
    @(posedge clk) cap_pin <= 1'b1;
    repeat (n) @(posedge clk);
    cap_pin <= 1'b0;
    repeat (6) @(posedge clk);
    i_cpu.rd16(ADR_CAP_LO, v);
  endtask
  // Edge polarity and the four-sample filter
  task automatic t_cap();
    i_cpu.wr16(ADR_CNT_LO, 16'h0042);
    i_cpu.wr(ADR_CTRL_B, 8'h40);
    pulse(2);
    check(v, 16'h0042);
    i_cpu.wr16(ADR_CNT_LO, 16'h0077);
    i_cpu.wr(ADR_CTRL_B, BYTE_RST);
    pulse(2);
    check(v, 16'h0077);
    i_cpu.wr16(ADR_CNT_LO, 16'h0099);
    i_cpu.wr(ADR_CTRL_B, 8'hc0);
    pulse(3);
    check(v, 16'h0077);
    pulse(4);
    check(v, 16'h0099);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bytes();
    t_div();
    t_clear();
    t_pwm();
    t_force();
    t_cap();
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    #(20000 * 50);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
